//--- logic/mfp_select.sv
// multifunction pin function selector: per-pin output mux and input decode
`timescale 1ns/1ps
`default_nettype none
`include "mfp_defs.svh"
// ----------------------------------------------------------------
// Notes on behaviour
// ----------------------------------------------------------------
// Notes on behaviour
// - direction bit one makes the pin an output using output codes.
// - direction bit zero makes the pin an input using input codes.
// - 0x80 low, 0x81 high, 0x82 system clock over 32, 0x83 watchdog.
// - 0x84 to 0x86 show upload, download and memory fault flags.
// - 0x87 to 0x8b show the five system and output pll flags.
// - 0x8c all three locks anded; 0x8d loop and analog lock anded.
// - 0x90 to 0x96 show the seven tracking loop state flags.
// - 0x97 clamped, 0x98 history available, 0x99 history updated.
// - 0xa0 to 0xa3 show fault of reference a to d.
// - 0xb0 to 0xb3 show valid of reference a to d.
// - 0xd0 sync pulse, 0xd1 soft pin configuration busy.
// - input 0x01 is update strobe, 0x02 is full power-down.
// - inputs 0x03 to 0x05 clear watchdog, interrupts, history.
// - input 0x10 forces holdover, 0x11 forces free run.
// - inputs 0x12 to 0x14 reset, increment, decrement phase offset.
// - inputs 0x20 to 0x23 override monitor of reference a to d.
// - inputs 0x30 to 0x33 force validation timeout of reference a to d.
// - inputs 0x40 to 0x45 enable clock output 0 to 5.
// - input 0x46 enables all six clock outputs together.
// - input 0x47 triggers soft sync of distribution outputs.
// ----------------------------------------------------------------

module mfp_select
#(
  parameter int NPINS = 4
)
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  // per-pin function codes
  input  wire logic [NPINS-1:0][7:0] func_code,
  // internal status
  input  wire mfp_pkg::mfp_status_s  status,
  // pins
  input  wire logic [NPINS-1:0]      pin_in,
  output logic      [NPINS-1:0]      pin_out,
  output logic      [NPINS-1:0]      pin_oe,
  // control actions from input pins, ored over all pins
  output mfp_pkg::mfp_ctrl_s         pin_ctrl
);
  import mfp_pkg::*;

  // ----------------------------------------------------------------
  // system clock divider
  // ----------------------------------------------------------------
  logic [4:0] div_cnt;
  logic       sysdiv;

  // divide by 32: toggle every 16 cycles of mclk
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt <= 5'h00;
      sysdiv  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (div_cnt == 5'(`MFP_SYSDIV_HALF - 1))
      begin
        div_cnt <= 5'h00;
        sysdiv  <= ~sysdiv;
      end
      else
        div_cnt <= div_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction

  // output function of one code
  function automatic logic out_value(input logic [7:0] c, input mfp_status_s s,
                                     input logic sd);
    logic [7:0] o;
    o = 8'h00;
    out_value = 1'b0;
    if (c == `MFP_O_LOW)
      out_value = 1'b0;
    else if (c == `MFP_O_HIGH)
      out_value = 1'b1;
    else if (c == `MFP_O_SYSDIV)
      out_value = sd;
    else if (c == `MFP_O_WDOG)
      out_value = s.wdog_out;
    else if (in_range(c, `MFP_O_MEM_FIRST, `MFP_O_MEM_LAST))
    begin
      o = c - `MFP_O_MEM_FIRST;
      out_value = s.mem_stat[o[1:0]];
    end
    else if (in_range(c, `MFP_O_PLL_FIRST, `MFP_O_PLL_LAST))
    begin
      o = c - `MFP_O_PLL_FIRST;
      out_value = s.pll_stat[o[2:0]];
    end
    else if (c == `MFP_O_ALL_LOCK)
      out_value = s.loop_phase_lock & s.analog_output_pll_lock & s.pll_stat[0];
    else if (c == `MFP_O_DA_LOCK)
      out_value = s.loop_phase_lock & s.analog_output_pll_lock;
    else if (in_range(c, `MFP_O_LOOP_FIRST, `MFP_O_LOOP_LAST))
    begin
      o = c - `MFP_O_LOOP_FIRST;
      out_value = s.loop_stat[o[2:0]];
    end
    else if (c == `MFP_O_CLAMP)
      out_value = s.freq_clamped;
    else if (c == `MFP_O_HIST_AVAIL)
      out_value = s.hist_avail;
    else if (c == `MFP_O_HIST_UPD)
      out_value = s.hist_updated;
    else if (in_range(c, `MFP_O_FAULT_FIRST, `MFP_O_FAULT_LAST))
      out_value = s.ref_fault[c[1:0]];
    else if (in_range(c, `MFP_O_VALID_FIRST, `MFP_O_VALID_LAST))
      out_value = s.ref_valid[c[1:0]];
    else if (in_range(c, `MFP_O_ACT_FIRST, `MFP_O_ACT_LAST))
      out_value = (s.active_ref == c[1:0]);
    else if (c == `MFP_O_SYNC_PULSE)
      out_value = s.sync_pulse;
    else if (c == `MFP_O_SOFT_CFG)
      out_value = s.soft_cfg_busy;
  endfunction

  // input action of one pin; reserved codes contribute nothing
  function automatic mfp_ctrl_s in_action(input logic [7:0] c, input logic lvl);
    mfp_ctrl_s a;
    a = '0;
    if (lvl)
    begin
      if (c == `MFP_I_UPDATE)
        a.io_update = 1'b1;
      else if (c == `MFP_I_PWRDN)
        a.power_down = 1'b1;
      else if (in_range(c, `MFP_I_CLR_FIRST, `MFP_I_CLR_LAST))
        a.clear[2'(c - `MFP_I_CLR_FIRST)] = 1'b1;
      else if (c == `MFP_I_HOLDOVER)
        a.user_holdover = 1'b1;
      else if (c == `MFP_I_FREERUN)
        a.user_freerun = 1'b1;
      else if (c == `MFP_I_PH_RESET)
        a.phase_step[2] = 1'b1;
      else if (c == `MFP_I_PH_INC)
        a.phase_step[0] = 1'b1;
      else if (c == `MFP_I_PH_DEC)
        a.phase_step[1] = 1'b1;
      else if (in_range(c, `MFP_I_OVR_FIRST, `MFP_I_OVR_LAST))
        a.monitor_override[c[1:0]] = 1'b1;
      else if (in_range(c, `MFP_I_VTO_FIRST, `MFP_I_VTO_LAST))
        a.force_timeout[c[1:0]] = 1'b1;
      else if (in_range(c, `MFP_I_OE_FIRST, `MFP_I_OE_LAST))
        a.out_enable[3'(c - `MFP_I_OE_FIRST)] = 1'b1;
      else if (c == `MFP_I_OE_ALL)
        a.out_enable = 6'h3f;
      else if (c == `MFP_I_SOFT_SYNC)
        a.soft_sync = 1'b1;
    end
    in_action = a;
  endfunction

  // ----------------------------------------------------------------
  // per-pin decode
  // ----------------------------------------------------------------
  logic [NPINS-1:0] next_pin_out;
  logic [NPINS-1:0] next_pin_oe;
  mfp_ctrl_s        next_ctrl;

  always_comb
  begin
    next_pin_out = '0;
    next_pin_oe  = '0;
    next_ctrl    = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      if (func_code[i][`MFP_DIR_BIT])
      begin
        next_pin_oe[i]  = 1'b1;
        next_pin_out[i] = out_value(func_code[i], status, sysdiv);
      end
      else
        // input: pin stays undriven, level drives the control action
        next_ctrl = next_ctrl | in_action(func_code[i], pin_in[i]);
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // one register stage keeps pin data glitch free across code changes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe  <= '0;
    end
    else if (clk_en)
    begin
      pin_out <= next_pin_out;
      pin_oe  <= next_pin_oe;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pin_ctrl <= '0;
    else if (clk_en)
      pin_ctrl <= next_ctrl;
  end

endmodule
`default_nettype wire

//--- shared/mfp_defs.svh
// constants for the multifunction pin function selector
`ifndef MFP_DEFS_SVH
`define MFP_DEFS_SVH

`define MFP_DIR_BIT        7
`define MFP_SYSDIV         32
`define MFP_SYSDIV_HALF    16
`define MFP_CODE_RESET     8'h00
// output codes
`define MFP_O_LOW          8'h80
`define MFP_O_HIGH         8'h81
`define MFP_O_SYSDIV       8'h82
`define MFP_O_WDOG         8'h83
`define MFP_O_MEM_FIRST    8'h84
`define MFP_O_MEM_LAST     8'h86
`define MFP_O_PLL_FIRST    8'h87
`define MFP_O_PLL_LAST     8'h8b
`define MFP_O_ALL_LOCK     8'h8c
`define MFP_O_DA_LOCK      8'h8d
`define MFP_O_LOOP_FIRST   8'h90
`define MFP_O_LOOP_LAST    8'h96
`define MFP_O_CLAMP        8'h97
`define MFP_O_HIST_AVAIL   8'h98
`define MFP_O_HIST_UPD     8'h99
`define MFP_O_FAULT_FIRST  8'ha0
`define MFP_O_FAULT_LAST   8'ha3
`define MFP_O_VALID_FIRST  8'hb0
`define MFP_O_VALID_LAST   8'hb3
`define MFP_O_ACT_FIRST    8'hc0
`define MFP_O_ACT_LAST     8'hc3
`define MFP_O_SYNC_PULSE   8'hd0
`define MFP_O_SOFT_CFG     8'hd1
// input codes
`define MFP_I_UPDATE       8'h01
`define MFP_I_PWRDN        8'h02
`define MFP_I_CLR_FIRST    8'h03
`define MFP_I_CLR_LAST     8'h05
`define MFP_I_HOLDOVER     8'h10
`define MFP_I_FREERUN      8'h11
`define MFP_I_PH_RESET     8'h12
`define MFP_I_PH_INC       8'h13
`define MFP_I_PH_DEC       8'h14
`define MFP_I_OVR_FIRST    8'h20
`define MFP_I_OVR_LAST     8'h23
`define MFP_I_VTO_FIRST    8'h30
`define MFP_I_VTO_LAST     8'h33
`define MFP_I_OE_FIRST     8'h40
`define MFP_I_OE_LAST      8'h45
`define MFP_I_OE_ALL       8'h46
`define MFP_I_SOFT_SYNC    8'h47

`endif

//--- shared/mfp_pkg.sv
// types for the multifunction pin function selector
package mfp_pkg;

  // internal status flags the pins can mirror
  typedef struct packed {
    logic       wdog_out;
    logic [2:0] mem_stat;      // upload, download, fault
    logic [4:0] pll_stat;      // sys lock, sys stable, out lock, calibrating, ref present
    logic       loop_phase_lock;
    logic       analog_output_pll_lock;
    logic [6:0] loop_stat;     // free run .. slew limited
    logic       freq_clamped;
    logic       hist_avail;
    logic       hist_updated;
    logic [3:0] ref_fault;     // a..d
    logic [3:0] ref_valid;     // a..d
    logic [1:0] active_ref;
    logic       sync_pulse;
    logic       soft_cfg_busy;
  } mfp_status_s;

  // control actions a pin in input mode can assert
  typedef struct packed {
    logic       io_update;
    logic       power_down;
    logic [2:0] clear;         // watchdog, irqs, history
    logic       user_holdover;
    logic       user_freerun;
    logic [2:0] phase_step;    // bit0 inc, bit1 dec, bit2 reset
    logic [3:0] monitor_override;
    logic [3:0] force_timeout;
    logic [5:0] out_enable;
    logic       soft_sync;
  } mfp_ctrl_s;

endpackage

//--- sim/mfp_board.sv
// board model: resolves each shared pin wire from both parties' drive
`timescale 1ns/1ps
`default_nettype none
module mfp_board
#(
  parameter int NPINS = 4
)
(
  // device side
  input  wire logic [NPINS-1:0] pin_out,
  input  wire logic [NPINS-1:0] pin_oe,
  // board drive, used only while the device leaves the pin alone
  input  wire logic [NPINS-1:0] drive,
  output logic      [NPINS-1:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & drive);
endmodule
`default_nettype wire

//--- sim/mfp_select_monitor.sv
// assertions on the multifunction pin selector ports
`timescale 1ns/1ps
`default_nettype none
module mfp_select_monitor
#(
  parameter int NPINS = 4
)
(
  // clock and reset
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  // observed ports
  input wire logic [NPINS-1:0][7:0] func_code,
  input wire mfp_pkg::mfp_status_s  status,
  input wire logic [NPINS-1:0]      pin_in,
  input wire logic [NPINS-1:0]      pin_out,
  input wire logic [NPINS-1:0]      pin_oe,
  input wire mfp_pkg::mfp_ctrl_s    pin_ctrl
);
  import mfp_pkg::*;
  logic [NPINS-1:0] dirv;
  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
      dirv[i] = func_code[i][7];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_out(logic [7:0] c); clk_en && func_code[0] == c; endsequence
  sequence s_in(logic [7:0] c); clk_en && func_code[0] == c && pin_in[0]; endsequence
  property p_oe_dir; clk_en |=> pin_oe == $past(dirv); endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("pin enable does not follow direction bit");
  property p_low; s_out(8'h80) |=> !pin_out[0]; endproperty
  a_low: assert property (p_low)
    else $error("static low code drives high");
  property p_high; s_out(8'h81) |=> pin_out[0]; endproperty
  a_high: assert property (p_high)
    else $error("static high code drives low");
  property p_mem;
    clk_en && func_code[0] inside {[8'h84:8'h86]} |=>
      pin_out[0] == $past(status.mem_stat[func_code[0][1:0]]);
  endproperty
  a_mem: assert property (p_mem)
    else $error("memory flag mirrored wrongly");
  property p_all_lock;
    s_out(8'h8c) |=> pin_out[0] == $past(status.loop_phase_lock & status.analog_output_pll_lock & status.pll_stat[0]);
  endproperty
  a_all_lock: assert property (p_all_lock)
    else $error("all-lock output wrong");
  property p_fault;
    clk_en && func_code[0][7:2] == 6'h28 |=> pin_out[0] == $past(status.ref_fault[func_code[0][1:0]]);
  endproperty
  a_fault: assert property (p_fault)
    else $error("reference fault output wrong");
  property p_active;
    clk_en && func_code[0][7:2] == 6'h30 |=>
      pin_out[0] == ($past(status.active_ref) == $past(func_code[0][1:0]));
  endproperty
  a_active: assert property (p_active)
    else $error("active reference output wrong");
  property p_sync; s_in(8'h47) |=> pin_ctrl.soft_sync; endproperty
  a_sync: assert property (p_sync)
    else $error("soft sync not asserted");
  property p_oe_all; s_in(8'h46) |=> &pin_ctrl.out_enable; endproperty
  a_oe_all: assert property (p_oe_all)
    else $error("not all output enables set");
  property p_idle; clk_en && func_code == '0 |=> pin_ctrl == '0; endproperty
  a_idle: assert property (p_idle)
    else $error("reserved input code produced an action");
endmodule
`default_nettype wire

//--- sim/mfp_select_tb_top.sv
// testbench for the multifunction pin selector
`timescale 1ns/1ps
`default_nettype none
module mfp_select_tb_top;
  import mfp_pkg::*;
  localparam int NPINS = 4;
  localparam int W = 2 * NPINS + $bits(mfp_ctrl_s);
  logic                  mclk;
  logic                  rst_n;
  logic                  clk_en;
  logic [NPINS-1:0][7:0] func_code;
  mfp_status_s           status;
  logic [NPINS-1:0]      pin_in;
  logic [NPINS-1:0]      pin_out;
  logic [NPINS-1:0]      pin_oe;
  logic [NPINS-1:0]      drive;
  mfp_ctrl_s             pin_ctrl;
  logic [W-1:0]          hold;
  logic [W-1:0]          notes[$];
  logic [NPINS-1:0][7:0] cc;
  integer                seed = 32'hfa924310;
  int                    n_fail = 0;
  int                    tests_run = 0;
  mfp_select #(.NPINS(NPINS)) u_mfp_select (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .func_code(func_code), .status(status), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_ctrl(pin_ctrl));
  mfp_board #(.NPINS(NPINS)) u_mfp_board (.pin_out(pin_out), .pin_oe(pin_oe), .drive(drive),
    .pin_in(pin_in));
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // reference decode
  // ----------------------------------------------------------------
  function automatic logic exp_o(logic [7:0] c, mfp_status_s s);
    case (c) inside
      8'h81: return 1'b1;
      8'h83: return s.wdog_out;
      [8'h84:8'h86]: return s.mem_stat[c - 8'h84];
      [8'h87:8'h8b]: return s.pll_stat[c - 8'h87];
      8'h8c: return s.loop_phase_lock & s.analog_output_pll_lock & s.pll_stat[0];
      8'h8d: return s.loop_phase_lock & s.analog_output_pll_lock;
      [8'h90:8'h96]: return s.loop_stat[c - 8'h90];
      8'h97: return s.freq_clamped;
      8'h98: return s.hist_avail;
      8'h99: return s.hist_updated;
      [8'ha0:8'ha3]: return s.ref_fault[c[1:0]];
      [8'hb0:8'hb3]: return s.ref_valid[c[1:0]];
      [8'hc0:8'hc3]: return s.active_ref == c[1:0];
      8'hd0: return s.sync_pulse;
      8'hd1: return s.soft_cfg_busy;
      default: return 1'b0;
    endcase
  endfunction
  function automatic mfp_ctrl_s exp_c(logic [7:0] c);
    mfp_ctrl_s r;
    r = '0;
    case (c) inside
      8'h01: r.io_update = 1'b1;
      8'h02: r.power_down = 1'b1;
      [8'h03:8'h05]: r.clear[c - 8'h03] = 1'b1;
      8'h10: r.user_holdover = 1'b1;
      8'h11: r.user_freerun = 1'b1;
      8'h12: r.phase_step[2] = 1'b1;
      [8'h13:8'h14]: r.phase_step[c - 8'h13] = 1'b1;
      [8'h20:8'h23]: r.monitor_override[c[1:0]] = 1'b1;
      [8'h30:8'h33]: r.force_timeout[c[1:0]] = 1'b1;
      [8'h40:8'h45]: r.out_enable[c - 8'h40] = 1'b1;
      8'h46: r.out_enable = '1;
      8'h47: r.soft_sync = 1'b1;
      default: r = '0;
    endcase
    return r;
  endfunction
  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one cycle: new codes, status and board levels; a frozen cycle expects the old outputs
  task automatic step(input logic en);
    logic [63:0]      rnd;
    logic [NPINS-1:0] lvl;
    logic [NPINS-1:0] eo;
    mfp_ctrl_s        ec;
    @(negedge mclk);
    rnd = {$random(seed), $random(seed)};
    clk_en = en;
    func_code = cc;
    status = rnd[$bits(mfp_status_s)-1:0];
    drive = NPINS'($random(seed));
    lvl = (hold[W-1 -: NPINS] & hold[W-1-NPINS -: NPINS]) | (~hold[W-1-NPINS -: NPINS] & drive);
    ec = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      eo[i] = cc[i][7] & exp_o(cc[i], status);
      if (!cc[i][7] && lvl[i])
        ec = ec | exp_c(cc[i]);
    end
    if (en)
      hold = {eo, dirs(cc), ec};
    notes.push_back(hold);
  endtask
  function automatic logic [NPINS-1:0] dirs(logic [NPINS-1:0][7:0] c);
    for (int i = 0; i < NPINS; i++)
      dirs[i] = c[i][7];
  endfunction
  task automatic pick_codes;
    for (int i = 0; i < NPINS; i++)
    begin
      cc[i] = 8'($random(seed));
      if (cc[i] == 8'h82)
        cc[i] = 8'h81;
    end
  endtask
  always @(posedge mclk)
  begin
    #1;
    if (notes.size() > 0)
      check({pin_out & pin_oe, pin_oe, pin_ctrl}, notes.pop_front());
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    give_verdict;
  end
  initial
  begin
    int   n;
    logic t;
    rst_n = 1'b0;
    clk_en = 1'b1;
    func_code = '0;
    status = '0;
    drive = '0;
    hold = '0;
    cc = {NPINS{8'h80}};
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    cc[0] = 8'h82;
    func_code = cc;
    n = 0;
    repeat (3)
    begin
      t = pin_out[0];
      n = 0;
      while (pin_out[0] === t && n < 40)
      begin
        @(posedge mclk);
        #1;
        n++;
      end
    end
    check(W'(n), W'(16));
    hold = {{NPINS{1'b0}}, {NPINS{1'b1}}, {$bits(mfp_ctrl_s){1'b0}}};
    $display("divider test done");
    for (int c = 0; c < 256; c++)
    begin
      pick_codes;
      cc[0] = 8'(c);
      if (c == 0)
        cc = '0;
      if (c != 'h82)
        step(1'b1);
    end
    $display("code table test done");
    repeat (300)
    begin
      pick_codes;
      step(($random(seed) & 7) != 0);
    end
    $display("random test done");
    repeat (2) @(posedge mclk);
    #2;
    give_verdict;
  end
endmodule
bind mfp_select mfp_select_monitor #(.NPINS(NPINS)) u_mfp_select_monitor (.mclk(mclk),
  .rst_n(rst_n), .clk_en(clk_en), .func_code(func_code), .status(status), .pin_in(pin_in),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_ctrl(pin_ctrl));
`default_nettype wire
